// >>> hw/self_program_flash_control.sv
// Self-programming flash sequencer with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "spm_ctrl_regs.svh"
module self_program_flash_control #(
    parameter int unsigned PAGE_WORDS      = 32,
    parameter int unsigned PAGE_COUNT      = 128,
    parameter int unsigned RWW_PAGES       = 112,
    parameter int unsigned WORD_BITS       = $clog2(PAGE_WORDS),
    parameter int unsigned PAGE_BITS       = $clog2(PAGE_COUNT),
    parameter logic [15:0] BOOT_RESET_ADDR = 16'h1F00,
    parameter logic [3:0]  BOOT_LOCK_INIT  = 4'hF
)(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   ce,
    input  wire logic [7:0]             awaddr,
    input  wire logic [2:0]             awprot,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    input  wire logic [7:0]             araddr,
    input  wire logic [2:0]             arprot,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    input  wire logic                   global_int_enable,
    input  wire logic                   boot_reset_fuse,
    input  wire logic [7:0]             fuse_low,
    input  wire logic [7:0]             fuse_high,
    input  wire logic [1:0]             lock_general,
    input  wire logic                   eeprom_write_busy,
    input  wire logic                   eeprom_write_start,
    input  wire logic                   flash_done,
    input  wire logic [WORD_BITS-1:0]   buf_rd_idx,
    output logic [15:0]                 reset_vector,
    output logic                        ready_irq,
    output logic                        section_busy_flag,
    output logic                        cpu_halt,
    output logic                        flash_start,
    output spm_ctrl_pkg::op_e           flash_op,
    output logic [PAGE_BITS-1:0]        flash_page,
    output logic [15:0]                 buf_rd_data,
    output logic [3:0]                  boot_lock
);
    import spm_ctrl_pkg::*;

    logic                 ready_interrupt_enable;
    logic [4:0]           cmd;
    logic [2:0]           age;
    op_e                  op_state;
    logic [15:0]          data_word_pair;
    logic [15:0]          pointer;
    logic [15:0]          page_buf [PAGE_WORDS];
    logic                 loaded;
    logic [7:0]           load_result;
    logic                 load_special;
    logic                 aw_held;
    logic                 w_held;
    logic [7:0]           aw_addr_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic                 wr_fire;
    reg_sel_e             wr_sel;
    logic                 ctrl_wr;
    logic                 ctrl_accept;
    logic                 store_fire;
    logic                 load_fire;
    logic                 accept_store;
    logic                 do_load;
    logic                 do_erase;
    logic                 do_write;
    logic                 do_lock;
    logic                 do_rww_en;
    logic                 do_read_fuse;
    logic                 op_finish;
    logic                 buf_clear;
    logic                 target_rww;

    function automatic reg_sel_e reg_sel(input logic [7:0] a);
        case (a)
            `OFF_CONTROL:     reg_sel = SEL_CONTROL;
            `OFF_DATA_WORD:   reg_sel = SEL_DATA;
            `OFF_POINTER:     reg_sel = SEL_POINTER;
            `OFF_INSTR:       reg_sel = SEL_INSTR;
            `OFF_LOAD_RESULT: reg_sel = SEL_LOAD;
            `OFF_STATUS:      reg_sel = SEL_STATUS;
            default:          reg_sel = SEL_NONE;
        endcase
    endfunction

    function automatic logic cmd_legal(input logic [4:0] c);
        cmd_legal = (c == `CMD_LOAD) || (c == `CMD_ERASE) ||
                    (c == `CMD_WRITE) || (c == `CMD_LOCK) ||
                    (c == `CMD_RWW_EN);
    endfunction

    // The pointer is a byte address; bit 0 only matters to loads.
    function automatic logic [WORD_BITS-1:0] word_of(input logic [15:0] z);
        word_of = z[WORD_BITS:1]; // see R17, see R13
    endfunction

    function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] z);
        page_of = z[WORD_BITS+PAGE_BITS:WORD_BITS+1]; // see R17
    endfunction

    assign wr_fire    = aw_held && w_held && !bvalid;
    assign wr_sel     = reg_sel(aw_addr_q);
    assign ctrl_wr    = wr_fire && (wr_sel == SEL_CONTROL) && w_strb_q[0];
    assign store_fire = wr_fire && (wr_sel == SEL_INSTR) && w_strb_q[0] &&
                        w_data_q[`BIT_INSTR_STORE];
    assign load_fire  = wr_fire && (wr_sel == SEL_INSTR) && w_strb_q[0] &&
                        w_data_q[`BIT_INSTR_LOAD];
    // Commands are dropped while an operation runs or the EEPROM writes.
    assign ctrl_accept = ctrl_wr && (op_state == OP_IDLE) &&
                         !eeprom_write_busy &&
                         cmd_legal(w_data_q[4:0]); // see R15, see R7, see R24
    assign accept_store = store_fire && cmd[0] && (age < `STORE_WINDOW) &&
                          (op_state == OP_IDLE) &&
                          !eeprom_write_busy; // see R14, see R24
    assign do_load   = accept_store && (cmd == `CMD_LOAD);
    assign do_erase  = accept_store && (cmd == `CMD_ERASE);
    assign do_write  = accept_store && (cmd == `CMD_WRITE);
    assign do_lock   = accept_store && (cmd == `CMD_LOCK);
    assign do_rww_en = accept_store && (cmd == `CMD_RWW_EN);
    assign do_read_fuse = load_fire && (cmd == `CMD_LOCK) &&
                          (age < `LOAD_WINDOW) && (op_state == OP_IDLE) &&
                          !eeprom_write_busy; // see R10, see R24
    assign op_finish  = (op_state != OP_IDLE) && flash_done; // see R25
    assign target_rww = page_of(pointer) < PAGE_BITS'(RWW_PAGES);
    assign buf_clear  = (op_finish && (op_state == OP_WRITE)) ||
                        (ctrl_accept && (w_data_q[4:0] == `CMD_RWW_EN)) ||
                        (eeprom_write_start && loaded); // see R8, see R20

    // Bus write channels: address and data are taken in either order.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
        end
        else if (ce)
        begin
            if (awvalid && awready)
            begin
                awready   <= 1'b0;
                aw_held   <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                wready   <= 1'b0;
                w_held   <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Bus read channel; reads have no side effects.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end
        else if (ce)
        begin
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rresp   <= `RESP_OKAY;
                case (reg_sel(araddr))
                    SEL_CONTROL: rdata <= {24'h0, ready_interrupt_enable,
                                           section_busy_flag, 1'b0,
                                           cmd}; // see R6
                    SEL_DATA:    rdata <= {16'h0, data_word_pair};
                    SEL_POINTER: rdata <= {16'h0, pointer};
                    SEL_LOAD:    rdata <= {23'h0, load_special, load_result};
                    SEL_STATUS:  rdata <= {28'h0, eeprom_write_busy, loaded,
                                           cpu_halt, op_state != OP_IDLE};
                    SEL_INSTR:   rdata <= 32'h0000_0000;
                    default:
                    begin
                        rdata <= 32'h0000_0000;
                        rresp <= `RESP_SLVERR;
                    end
                endcase
            end
            if (rvalid && rready)
            begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // Data pair, pointer and interrupt enable are plain software storage.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            data_word_pair         <= 16'h0000;
            pointer                <= 16'h0000;
            ready_interrupt_enable <= 1'b0;
        end
        else if (ce && wr_fire)
        begin
            if (wr_sel == SEL_CONTROL && w_strb_q[0])
                ready_interrupt_enable <= w_data_q[`BIT_READY_IE];
            if (wr_sel == SEL_DATA && w_strb_q[0])
                data_word_pair[7:0] <= w_data_q[7:0];
            if (wr_sel == SEL_DATA && w_strb_q[1])
                data_word_pair[15:8] <= w_data_q[15:8];
            if (wr_sel == SEL_POINTER && w_strb_q[0])
                pointer[7:0] <= w_data_q[7:0];
            if (wr_sel == SEL_POINTER && w_strb_q[1])
                pointer[15:8] <= w_data_q[15:8];
        end
    end

    // Command arming window and the erase/write sequence.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmd         <= 5'h00;
            age         <= 3'h0;
            op_state    <= OP_IDLE;
            flash_start <= 1'b0;
            flash_op    <= OP_IDLE;
            flash_page  <= '0;
            cpu_halt    <= 1'b0;
            boot_lock   <= BOOT_LOCK_INIT;
        end
        else if (ce)
        begin
            flash_start <= 1'b0;
            if (op_state != OP_IDLE)
            begin
                // Store enable stays set until the array reports done.
                if (flash_done)
                begin
                    op_state <= OP_IDLE; // see R14, see R11, see R12
                    flash_op <= OP_IDLE;
                    cmd      <= 5'h00;
                    cpu_halt <= 1'b0;
                end
            end
            else if (ctrl_accept)
            begin
                cmd <= w_data_q[4:0]; // see R15
                age <= 3'h0;
            end
            else if (do_erase || do_write)
            begin
                op_state    <= do_erase ? OP_ERASE : OP_WRITE;
                flash_op    <= do_erase ? OP_ERASE : OP_WRITE;
                flash_start <= 1'b1;
                flash_page  <= page_of(pointer); // see R16, see R11, see R12
                cpu_halt    <= !target_rww; // see R21
            end
            else if (accept_store || do_read_fuse)
            begin
                // Lock bits only ever go from unprogrammed to programmed.
                if (do_lock)
                    boot_lock <= boot_lock & data_word_pair[5:2]; // see R9
                cmd <= 5'h00; // see R14
            end
            else if (cmd[0])
            begin
                if (age == `STORE_WINDOW - 3'h1)
                    cmd <= 5'h00; // see R14, see R12
                else
                    age <= age + 3'h1;
            end
        end
    end

    // A new operation setting busy outranks any clear in the same cycle.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            section_busy_flag <= 1'b0;
        else if (ce)
        begin
            if ((do_erase || do_write) && target_rww)
                section_busy_flag <= 1'b1; // see R4
            else if (do_load || do_rww_en)
                section_busy_flag <= 1'b0; // see R5, see R7
        end
    end

    // Temporary page buffer; a load in the same cycle as a discard survives.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < PAGE_WORDS; i++)
                page_buf[i] <= `BUF_ERASED; // see R18
            loaded      <= 1'b0;
            buf_rd_data <= `BUF_ERASED;
        end
        else if (ce)
        begin
            if (buf_clear)
            begin
                for (int i = 0; i < PAGE_WORDS; i++)
                    page_buf[i] <= `BUF_ERASED; // see R18, see R8, see R20
                loaded <= 1'b0;
            end
            if (do_load)
            begin
                page_buf[word_of(pointer)] <= data_word_pair; // see R13
                loaded <= 1'b1;
            end
            buf_rd_data <= page_buf[buf_rd_idx];
        end
    end

    // Fuses are inputs only; nothing here can write them.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            load_result  <= 8'h00;
            load_special <= 1'b0;
        end
        else if (ce)
        begin
            if (do_read_fuse)
            begin
                load_special <= 1'b1;
                // Pointer 1 reads the lock byte, pointer 3 the high fuse byte.
                if (pointer[1:0] == 2'b01)
                    load_result <= {2'h3, boot_lock, lock_general}; // see R23
                else
                    load_result <= pointer[1] ? fuse_high : fuse_low; // see R2
            end
            else if (load_fire)
                load_special <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ready_irq    <= 1'b0;
            reset_vector <= `APP_RESET_ADDR;
        end
        else if (ce)
        begin
            ready_irq <= ready_interrupt_enable && global_int_enable &&
                         !cmd[0]; // see R3
            reset_vector <= boot_reset_fuse ? `APP_RESET_ADDR
                                            : BOOT_RESET_ADDR; // see R1
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_lock_armed;
        ce && ctrl_accept && (w_data_q[4:0] == `CMD_LOCK);
    endsequence

    sequence s_op_start;
        ce && (do_erase || do_write);
    endsequence

    property p_reserved_zero;
        rvalid |-> !(rdata[5] && $past(reg_sel(araddr)) == SEL_CONTROL);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // see R6
        else $error("reserved control bit read as one");

    property p_ready_irq;
        ce && ready_interrupt_enable && global_int_enable && !cmd[0]
            |=> ready_irq;
    endproperty
    a_ready_irq: assert property (p_ready_irq) // see R3
        else $error("ready interrupt missing while store enable clear");

    property p_window_lapse;
        ce && ctrl_accept ##1 (ce && !store_fire && !load_fire &&
            !ctrl_wr)[*4] |=> !cmd[0];
    endproperty
    a_window_lapse: assert property (p_window_lapse) // see R14
        else $error("store enable outlived its four cycle window");

    property p_busy_set;
        s_op_start and target_rww |=> section_busy_flag && flash_start;
    endproperty
    a_busy_set: assert property (p_busy_set) // see R4
        else $error("busy flag not set on shared section operation");

    property p_busy_clear_load;
        ce && do_load |=> !section_busy_flag && loaded;
    endproperty
    a_busy_clear_load: assert property (p_busy_clear_load) // see R5
        else $error("page load did not clear busy flag");

    property p_lock_done;
        s_lock_armed ##[1:4] (ce && do_lock) |=> cmd == 5'h00;
    endproperty
    a_lock_done: assert property (p_lock_done) // see R9
        else $error("lock set bit did not self clear");

    property p_write_clears_buf;
        ce && op_finish && op_state == OP_WRITE && !do_load |=> !loaded;
    endproperty
    a_write_clears_buf: assert property (p_write_clears_buf) // see R18
        else $error("buffer not erased after page write");

    property p_page_hold;
        ce && op_state != OP_IDLE && !flash_done
            |=> $stable(flash_page) && cmd[0];
    endproperty
    a_page_hold: assert property (p_page_hold) // see R16
        else $error("latched page or store enable changed mid operation");

    property p_illegal_ignored;
        ce && ctrl_wr && !cmd_legal(w_data_q[4:0]) && !op_finish &&
            !(cmd[0] && age == `STORE_WINDOW - 3'h1) |=> $stable(cmd);
    endproperty
    a_illegal_ignored: assert property (p_illegal_ignored) // see R15
        else $error("illegal command pattern changed the command");

    property p_halt;
        s_op_start and !target_rww |=> cpu_halt;
    endproperty
    a_halt: assert property (p_halt) // see R21
        else $error("processor not halted for other section operation");
endmodule

// >>> pkg/spm_ctrl_regs.svh
// Register offsets, field positions, reset values and counts of the flash sequencer.
// Function
// R1: After reset, fetch from zero if the boot fuse reads 1, else boot address.
// R2: Processor software has no way to change fuse values.
// R3: Ready interrupt stays asserted while enabled and store enable is clear.
// R4: Erase or write of the shared section sets busy and blocks its reads.
// R5: Busy clears by section read enable after completion, or by a page load.
// R6: Control bit 5 is reserved and always reads zero.
// R7: Read enable with store enable re-enables the section; ignored while busy.
// R8: Read enable written during buffer loading aborts the load, losing data.
// R9: Lock set programs boot lock bits from low data; self-clears.
// R10: Load within three cycles of lock set returns lock or fuse bits.
// R11: Page write stores the buffer into the pointer's page; self-clears.
// R12: Page erase clears the pointer's page; self-clears on completion or lapse.
// R13: Plain store enable puts the data pair into the buffer word addressed.
// R14: Store enable arms four cycles, held during erase and write.
// R15: Only the five listed command patterns act; others are ignored.
// R16: Target page is latched when an operation starts.
// R17: Pointer low bits select the word, high bits select the page.
// R18: Buffer erased after page write, on read enable, and on reset.
// R19: Software writes each buffer word at most once between erasures.
// R20: An EEPROM write during page loading discards the buffered data.
// R21: Erase X0000011, write X0000101; shared section runs, other section halts.
// R22: Software erases a page before writing it, with the same page address.
// R23: Lock byte has boot lock in bits 5 to 2, general lock in 1 to 0.
// R24: EEPROM write blocks flash programming and fuse or lock reads.
// R25: Page geometry and done pulse come from build parameters and the array.
`ifndef SPM_CTRL_REGS_SVH
`define SPM_CTRL_REGS_SVH
`define OFF_CONTROL     8'h00
`define OFF_DATA_WORD   8'h04
`define OFF_POINTER     8'h08
`define OFF_INSTR       8'h0C
`define OFF_LOAD_RESULT 8'h10
`define OFF_STATUS      8'h14
`define BIT_READY_IE    7
`define BIT_BUSY        6
`define BIT_INSTR_STORE 0
`define BIT_INSTR_LOAD  1
`define CMD_LOAD        5'h01
`define CMD_ERASE       5'h03
`define CMD_WRITE       5'h05
`define CMD_LOCK        5'h09
`define CMD_RWW_EN      5'h11
`define STORE_WINDOW    3'h4
`define LOAD_WINDOW     3'h3
`define APP_RESET_ADDR  16'h0000
`define BUF_ERASED      16'hFFFF
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// >>> pkg/spm_ctrl_pkg.sv
// Types shared by the flash sequencer.
package spm_ctrl_pkg;
    typedef enum {OP_IDLE, OP_ERASE, OP_WRITE} op_e;
    typedef enum {SEL_CONTROL, SEL_DATA, SEL_POINTER, SEL_INSTR,
                  SEL_LOAD, SEL_STATUS, SEL_NONE} reg_sel_e;
endpackage

// >>> tb/flash_timer_model.sv
// Flash array timer model that ends each started operation with a done pulse.
`timescale 1ns/1ps
module flash_timer_model #(
    parameter int DLY = 40
)(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic flash_start,
    output logic      flash_done
);
    int cnt;
    // A long wait keeps each busy state visible to register reads.
    always_ff @(posedge aclk)
    begin
        flash_done <= aresetn && cnt == 1;
        if (!aresetn)
            cnt <= 0;
        else if (flash_start)
            cnt <= DLY;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
endmodule

// >>> tb/self_program_flash_control_test.sv
// Self-checking bench for the self-programming flash sequencer.
`timescale 1ns/1ps
module self_program_flash_control_test;
    import spm_ctrl_pkg::*;
    typedef struct {logic [15:0] p; logic [7:0] v; logic [31:0] e;} row_s;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic        rready = 0, gie = 1, fuse = 1, ee_st = 0, ee_bsy = 0;
    logic        awready, wready, bvalid, arready, rvalid, irq, busy, halt;
    logic        f_st, f_dn;
    logic [7:0]  awaddr = 0, araddr = 0, fl = 0, fh = 0;
    logic [31:0] wdata = 0, rdata, r;
    logic [1:0]  bresp, rresp, lg = 0, s;
    logic [4:0]  idx = 0;
    logic [15:0] rvec, bdata;
    logic [6:0]  fpage;
    logic [3:0]  blk;
    op_e         fop;
    int          miscompares = 0, n_tests = 0;
    row_s        rows[4] = '{'{16'h0000, 8'h5A, 32'h15A},
        '{16'h0002, 8'h5A, 32'h1A5}, '{16'h0001, 8'h5A, 32'h1FE},
        '{16'h0003, 8'h3C, 32'h1C3}};
    always #2 aclk = ~aclk;
    self_program_flash_control i_self_program_flash_control (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .global_int_enable(gie),
        .boot_reset_fuse(fuse), .fuse_low(fl), .fuse_high(fh),
        .lock_general(lg), .eeprom_write_busy(ee_bsy),
        .eeprom_write_start(ee_st), .flash_done(f_dn), .buf_rd_idx(idx),
        .reset_vector(rvec), .ready_irq(irq), .section_busy_flag(busy),
        .cpu_halt(halt), .flash_start(f_st), .flash_op(fop),
        .flash_page(fpage), .buf_rd_data(bdata), .boot_lock(blk));
    flash_timer_model i_flash_timer_model (.aclk(aclk), .aresetn(aresetn),
        .flash_start(f_st), .flash_done(f_dn));
    task automatic close_out();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e, input string m);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected at %0t: %s got %0h", $time, m, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic hang(input int n);
        if (n >= 100)
        begin
            miscompares++;
            $display("unexpected at %0t: wait timed out", $time);
            close_out();
        end
    endtask
    // The bench ties bready high, so back-to-back writes never clash.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end
        while (!bvalid && n < 100);
        s = bresp;
        hang(n);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end
        while (!rvalid && n < 100);
        r = rdata;
        s = rresp;
        rready <= 1'b0;
        hang(n);
    endtask
    task automatic cmd(input logic [15:0] p, input logic [7:0] c);
        wr(8'h08, 32'(p));
        wr(8'h00, 32'(c));
        wr(8'h0C, 32'h1);
        tick(2);
    endtask
    task automatic bufw(input logic [4:0] i, input logic [15:0] e);
        idx <= i;
        tick(2);
        chk(32'(bdata), 32'(e), "buffer word");
    endtask
    task automatic idle_wait();
        int n;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (fop !== OP_IDLE && n < 100);
        hang(n);
    endtask
    initial
    begin
        tick(10);
        aresetn <= 1'b1;
        tick(2);
        chk(32'(rvec), 32'h0, "vector");
        bufw(5'h0, 16'hFFFF);
        rd(8'h00);
        chk(r, 32'h0, "control");
        fuse <= 1'b0;
        tick(3);
        chk(32'(rvec), 32'h1F00, "boot vector");
        $display("test reset done");
        foreach (rows[i])
        begin
            fl <= rows[i].v;
            fh <= ~rows[i].v;
            lg <= rows[i].v[1:0];
            wr(8'h08, 32'(rows[i].p));
            wr(8'h00, 32'h09);
            wr(8'h0C, 32'h2);
            rd(8'h10);
            chk(r, rows[i].e, "fuse read");
        end
        $display("test fuse rows done");
        wr(8'h04, 32'h1234);
        cmd(16'h0087, 8'h01);
        bufw(5'h3, 16'h1234);
        wr(8'h08, 32'h8);
        wr(8'h00, 32'h01);
        tick(8);
        wr(8'h0C, 32'h1);
        bufw(5'h4, 16'hFFFF);
        wr(8'h00, 32'h87);
        rd(8'h00);
        chk(r, 32'h80, "illegal pattern");
        chk(32'(irq), 32'h1, "irq on");
        gie <= 1'b0;
        tick(3);
        chk(32'(irq), 32'h0, "irq off");
        gie <= 1'b1;
        $display("test load and arm done");
        cmd(16'h0080, 8'h03);
        wr(8'h08, 32'h0);
        chk(32'(fop), 32'(OP_ERASE), "erase op");
        chk(32'(fpage), 32'h2, "latched page");
        chk(32'(busy), 32'h1, "busy");
        chk(32'(halt), 32'h0, "no halt");
        rd(8'h00);
        chk(r, 32'h43, "armed during op");
        cmd(16'h0000, 8'h11);
        chk(32'(busy), 32'h1, "enable ignored");
        idle_wait();
        cmd(16'h0000, 8'h11);
        chk(32'(busy), 32'h0, "busy cleared");
        bufw(5'h3, 16'hFFFF);
        wr(8'h04, 32'hABCD);
        cmd(16'h1E00, 8'h01);
        ee_st <= 1'b1;
        tick(1);
        ee_st <= 1'b0;
        bufw(5'h0, 16'hFFFF);
        cmd(16'h1E00, 8'h03);
        idle_wait();
        cmd(16'h1E00, 8'h01);
        cmd(16'h1E00, 8'h05);
        chk(32'(halt), 32'h1, "halt");
        chk(32'(fpage), 32'h78, "write page");
        chk(32'(busy), 32'h0, "other section");
        idle_wait();
        tick(2);
        chk(32'(halt), 32'h0, "halt end");
        bufw(5'h0, 16'hFFFF);
        $display("test erase and write done");
        wr(8'h04, 32'hE7);
        cmd(16'h0001, 8'h09);
        chk(32'(blk), 32'h9, "lock set");
        ee_bsy <= 1'b1;
        wr(8'h00, 32'h09);
        rd(8'h00);
        chk(r, 32'h0, "eeprom block");
        ee_bsy <= 1'b0;
        wr(8'h40, 32'h1);
        chk(32'(s), 32'h2, "unmapped write");
        rd(8'h40);
        chk(32'(s), 32'h2, "unmapped read");
        $display("test lock and refusals done");
        wr(8'h04, 32'h77);
        cmd(16'h0000, 8'h01);
        aresetn <= 1'b0;
        tick(2);
        aresetn <= 1'b1;
        bufw(5'h0, 16'hFFFF);
        $display("test mid reset done");
        close_out();
    end
endmodule
